// ==== core/cycle_timer.sv ====
// loadable down-counter that flags its last cycle
`default_nettype none
module cycle_timer #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire logic [W-1:0] count,
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt_reg;   // cycles left
  logic [W-1:0] cnt_next;

  if (W < 2) begin : g_chk
    $error("cycle_timer needs at least two bits");
  end

  // a fresh start restarts the count
  always_comb begin
    if (start) begin
      cnt_next = count;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - W'(1);
    end else begin
      cnt_next = '0;
    end
  end

  // count register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign busy = (cnt_reg != '0);
  assign done = (cnt_reg == W'(1)) & ~start;

endmodule
`default_nettype wire

// ==== core/dram_training_core.sv ====
// device-side training, reference and mode register timing logic
//
// Functional notes
// - training sample shown on data within twenty ns
// - crowded samples dropped, last one still answered
// - reference settles in 250 or 80 ns
// - data floats fast after enable rises
// - termination switches within twenty ns of enable edges, only while command bus training is selected
// - preamble training drives strobe within delay, except while command bus training is active
`include "dram_training_map.svh"
`default_nettype none
module dram_training_core #(
  parameter int CA_W = 6,
  parameter int DQ_W = 8,
  parameter int TW   = 8
) (
  input  wire logic                           clk,
  input  wire logic                           rstn,
  input  wire logic                           link_ck,
  input  wire logic                           cke_pin,
  input  wire logic                           cs_pin,
  input  wire logic [CA_W-1:0]                ca_pin,
  input  wire logic                           dqs_t_in,
  output dram_training_pkg::strobe_drive_t    strobe_drive,
  output logic      [DQ_W-1:0]                dq_out,
  output logic                                dq_oe,
  output logic                                odt_on,
  output logic                                vref_busy,
  output logic      [5:0]                     vref_code,
  output logic                                cbt_mode,
  output logic                                leveling_mode,
  output logic                                preamble_mode
);

  // figures used as delay bounds below
  localparam int ADR_CYC   = `ASYNC_TRAINING_READ_DELAY_CYC;
  localparam int LONG_CYC  = `REFERENCE_MULTI_STEP_TIME_CYC;
  localparam int SHORT_CYC = `REFERENCE_SINGLE_STEP_TIME_CYC;
  localparam int FLOAT_CYC = `TRAINING_EXIT_OUTPUT_FLOAT_CYC;
  localparam int LONG_LO   = LONG_CYC - 1;   // early bound of the long settle
  localparam int SHORT_LO  = SHORT_CYC - 1;  // early bound of the short settle

  // refuse shapes the field decode or timers cannot serve; the longest load is the multi step settle
  if (CA_W < 6 || DQ_W <= CA_W || TW < 5) begin : g_chk
    $error("dram_training_core: need CA_W >= 6, DQ_W > CA_W, TW >= 5");
  end

  // ---------------- link domain ----------------
  dram_training_pkg::mode_word_t link_word_reg;  // last mode write seen
  dram_training_pkg::mode_word_t link_word_next;
  logic                          link_tog_reg;   // flips once per mode write
  logic                          link_tog_next;
  logic                          mode_hit;       // mode write on this edge

  // decode a mode register write on the command clock
  always_comb begin
    mode_hit       = cke_pin & cs_pin & (ca_pin[`CA_OP_MSB:`CA_OP_LSB] == `MODE_WRITE_OP);
    link_word_next = link_word_reg;
    link_tog_next  = link_tog_reg;
    if (mode_hit) begin
      link_word_next.field = dram_training_pkg::mode_field_t'(ca_pin[`CA_FIELD_MSB:`CA_FIELD_LSB]);
      link_word_next.value = ca_pin[`CA_VALUE_MSB:`CA_VALUE_LSB];
      link_tog_next        = ~link_tog_reg;
    end
  end

  // link-side registers
  always_ff @(posedge link_ck or negedge rstn) begin
    if (!rstn) begin
      link_word_reg <= '0;
      link_tog_reg  <= 1'b0;
    end else begin
      link_word_reg <= link_word_next;
      link_tog_reg  <= link_tog_next;
    end
  end

  // ---------------- crossings into the core clock ----------------
  logic            cke_s;     // enable pin, settled
  logic            strobe_s;  // true strobe pin, settled
  logic [CA_W-1:0] ca_s;      // command/address pins, settled
  logic            tog_s;     // mode write toggle, settled

  pin_sync #(.W(1)) u_cke_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (cke_pin),
    .level (cke_s)
  );

  pin_sync #(.W(1)) u_strobe_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (dqs_t_in),
    .level (strobe_s)
  );

  pin_sync #(.W(CA_W)) u_ca_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (ca_pin),
    .level (ca_s)
  );

  pin_sync #(.W(1)) u_tog_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (link_tog_reg),
    .level (tog_s)
  );

  // ---------------- mode state ----------------
  logic       tog_seen_reg;   // toggle level already acted on
  logic       cke_prev_reg;   // enable one cycle ago
  logic       strobe_prev_reg; // strobe one cycle ago
  logic       cbt_en_reg;     // command bus training selected
  logic       cbt_en_next;
  logic       level_en_reg;   // write leveling selected
  logic       level_en_next;
  logic       pre_en_reg;     // read preamble training selected
  logic       pre_en_next;
  logic [5:0] vref_code_reg;  // reference setting
  logic [5:0] vref_code_next;
  logic       mode_event;     // new mode write arrived
  logic       vref_start;     // reference step begins
  logic       pre_start;      // preamble training switched on
  logic [TW-1:0] vref_load;   // settle count for this step
  dram_training_pkg::mode_word_t word;

  // apply a mode write; word is steady since writes are spaced apart
  always_comb begin
    word           = link_word_reg;
    mode_event     = tog_s ^ tog_seen_reg;
    cbt_en_next    = cbt_en_reg;
    level_en_next  = level_en_reg;
    pre_en_next    = pre_en_reg;
    vref_code_next = vref_code_reg;
    vref_start     = 1'b0;
    pre_start      = 1'b0;
    vref_load      = TW'(`REFERENCE_SINGLE_STEP_TIME_CYC);
    if (mode_event) begin
      unique case (word.field)
        dram_training_pkg::FIELD_CBT: begin
          cbt_en_next = word.value[0];
        end
        dram_training_pkg::FIELD_LEVEL: begin
          level_en_next = word.value[0];
        end
        dram_training_pkg::FIELD_PREAMBLE: begin
          pre_en_next = word.value[0];
          pre_start   = word.value[0] & ~pre_en_reg;
        end
        dram_training_pkg::FIELD_VREF: begin
          // step count picks the long or short settle time
          vref_code_next = vref_code_reg + 6'(word.value);
          vref_start     = (word.value != 2'h0);
          if (word.value > 2'h1) begin
            vref_load = TW'(`REFERENCE_MULTI_STEP_TIME_CYC);
          end
        end
      endcase
    end
  end

  // mode registers and edge history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tog_seen_reg    <= 1'b0;
      cke_prev_reg    <= 1'b0;
      strobe_prev_reg <= 1'b0;
      cbt_en_reg      <= 1'b0;
      level_en_reg    <= 1'b0;
      pre_en_reg      <= 1'b0;
      vref_code_reg   <= `VREF_CODE_RESET;
    end else begin
      tog_seen_reg    <= tog_s;
      cke_prev_reg    <= cke_s;
      strobe_prev_reg <= strobe_s;
      cbt_en_reg      <= cbt_en_next;
      level_en_reg    <= level_en_next;
      pre_en_reg      <= pre_en_next;
      vref_code_reg   <= vref_code_next;
    end
  end

  // reference settle timer
  cycle_timer #(.W(TW)) u_vref_timer (
    .clk   (clk),
    .rstn  (rstn),
    .start (vref_start),
    .count (vref_load),
    .busy  (vref_busy),
    .done  ()
  );

  // ---------------- command bus training answer ----------------
  dram_training_pkg::cbt_state_t cbt_state_reg;  // answer state
  dram_training_pkg::cbt_state_t cbt_state_next;
  logic [CA_W-1:0] sample_reg;   // captured command/address sample
  logic [CA_W-1:0] sample_next;
  logic [DQ_W-1:0] dq_reg;       // data shown on the outputs
  logic [DQ_W-1:0] dq_next;
  logic            cbt_active;   // training entered and enable low
  logic            strobe_rise;  // sampling strobe edge
  logic            take;         // sample taken this cycle
  logic            adr_done;     // answer delay elapsed

  assign cbt_active  = cbt_en_reg & ~cke_s;
  assign strobe_rise = strobe_s & ~strobe_prev_reg;
  assign take        = strobe_rise & cbt_active;

  // answer delay, restarted by every sample
  cycle_timer #(.W(TW)) u_adr_timer (
    .clk   (clk),
    .rstn  (rstn),
    .start (take),
    .count (TW'(ADR_CYC)),
    .busy  (),
    .done  (adr_done)
  );

  // next answer state and shown data
  always_comb begin
    cbt_state_next = cbt_state_reg;
    sample_next    = sample_reg;
    dq_next        = dq_reg;
    if (take) begin
      sample_next = ca_s;  // a crowded earlier sample is overwritten
    end
    unique case (cbt_state_reg)
      dram_training_pkg::CBT_IDLE: begin
        if (take) begin
          cbt_state_next = dram_training_pkg::CBT_WAIT;
        end
      end
      dram_training_pkg::CBT_WAIT: begin
        if (!cbt_active) begin
          cbt_state_next = dram_training_pkg::CBT_IDLE;
        end else if (take) begin
          cbt_state_next = dram_training_pkg::CBT_WAIT;
        end else if (adr_done) begin
          cbt_state_next = dram_training_pkg::CBT_SHOW;
          dq_next        = {{(DQ_W-CA_W){1'b0}}, sample_reg};
        end
      end
      dram_training_pkg::CBT_SHOW: begin
        if (!cbt_active) begin
          cbt_state_next = dram_training_pkg::CBT_IDLE;
        end else if (take) begin
          cbt_state_next = dram_training_pkg::CBT_WAIT;
        end
      end
      default: begin
        cbt_state_next = dram_training_pkg::CBT_IDLE;
      end
    endcase
  end

  // answer registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cbt_state_reg <= dram_training_pkg::CBT_IDLE;
      sample_reg    <= '0;
      dq_reg        <= '0;
    end else begin
      cbt_state_reg <= cbt_state_next;
      sample_reg    <= sample_next;
      dq_reg        <= dq_next;
    end
  end

  // ---------------- termination ----------------
  logic          odt_reg;         // termination state
  logic          odt_next;
  logic          odt_target_reg;  // state to reach when the timer ends
  logic          odt_target_next;
  logic          odt_start;       // enable edge while training selected
  logic          odt_done;
  logic [TW-1:0] odt_load;

  // choose latency by direction of the enable edge
  always_comb begin
    odt_start       = (cke_s ^ cke_prev_reg) & cbt_en_reg;
    odt_load        = cke_s ? TW'(`TERMINATION_OFF_LATENCY_CYC) : TW'(`TERMINATION_ON_LATENCY_CYC);
    odt_target_next = odt_start ? ~cke_s : odt_target_reg;
    odt_next        = odt_done ? odt_target_reg : odt_reg;
  end

  cycle_timer #(.W(TW)) u_odt_timer (
    .clk   (clk),
    .rstn  (rstn),
    .start (odt_start),
    .count (odt_load),
    .busy  (),
    .done  (odt_done)
  );

  // termination registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      odt_reg        <= 1'b0;
      odt_target_reg <= 1'b0;
    end else begin
      odt_reg        <= odt_next;
      odt_target_reg <= odt_target_next;
    end
  end

  // ---------------- read preamble training strobe ----------------
  logic pre_drive_reg;  // strobe pair driven static preamble
  logic pre_drive_next;
  logic pre_done;

  cycle_timer #(.W(TW)) u_pre_timer (
    .clk   (clk),
    .rstn  (rstn),
    .start (pre_start),
    .count (TW'(`PREAMBLE_TRAINING_DRIVE_DELAY_CYC)),
    .busy  (),
    .done  (pre_done)
  );

  // drive starts when the delay ends, stops as soon as disabled
  always_comb begin
    pre_drive_next = pre_en_reg & (pre_drive_reg | pre_done);
  end

  // preamble drive register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_drive_reg <= 1'b0;
    end else begin
      pre_drive_reg <= pre_drive_next;
    end
  end

  // ---------------- outputs ----------------
  assign strobe_drive.out_t = 1'b0;
  assign strobe_drive.out_c = 1'b1;
  assign strobe_drive.oe    = pre_drive_reg & ~cbt_active;
  assign dq_out             = dq_reg;
  assign dq_oe              = (cbt_state_reg == dram_training_pkg::CBT_SHOW);
  assign odt_on             = odt_reg;
  assign vref_code          = vref_code_reg;
  assign cbt_mode           = cbt_en_reg;
  assign leveling_mode      = level_en_reg;
  assign preamble_mode      = pre_en_reg;

  // ---------------- checks ----------------
  sequence s_clean_sample;
    take ##1 (!strobe_rise && cbt_active)[*2];
  endsequence

  property p_answer_time;
    @(posedge clk) disable iff (!rstn)
    s_clean_sample |=> dq_oe && (dq_out[CA_W-1:0] == $past(sample_reg));
  endproperty
  a_answer_time: assert property (p_answer_time) else $error("sample not shown in time");

  property p_drop_crowded;
    @(posedge clk) disable iff (!rstn)
    (cbt_state_reg != dram_training_pkg::CBT_IDLE) && take |=> !dq_oe && (sample_reg == $past(ca_s));
  endproperty
  a_drop_crowded: assert property (p_drop_crowded) else $error("crowded sample not dropped");

  property p_exit_float;
    @(posedge clk) disable iff (!rstn)
    $rose(cke_s) |-> ##[1:FLOAT_CYC] !dq_oe;
  endproperty
  a_exit_float: assert property (p_exit_float) else $error("data not floated on exit");

  property p_odt_on;
    @(posedge clk) disable iff (!rstn)
    $fell(cke_s) && cbt_en_reg ##1 (!cke_s)[*3] |-> odt_on;
  endproperty
  a_odt_on: assert property (p_odt_on) else $error("termination late on entry");

  property p_odt_off;
    @(posedge clk) disable iff (!rstn)
    $rose(cke_s) && cbt_en_reg ##1 cke_s[*3] |-> !odt_on;
  endproperty
  a_odt_off: assert property (p_odt_off) else $error("termination late on exit");

  property p_vref_long;
    @(posedge clk) disable iff (!rstn)
    vref_start && (word.value > 2'h1) |=> vref_busy ##[LONG_LO:LONG_CYC] !vref_busy;
  endproperty
  a_vref_long: assert property (p_vref_long) else $error("multi step settle wrong");

  property p_vref_short;
    @(posedge clk) disable iff (!rstn)
    vref_start && (word.value == 2'h1) |=> vref_busy ##[SHORT_LO:SHORT_CYC] !vref_busy;
  endproperty
  a_vref_short: assert property (p_vref_short) else $error("single step settle wrong");

  property p_preamble_drive;
    @(posedge clk) disable iff (!rstn)
    pre_start ##1 (pre_en_reg && !cbt_active)[*3] |-> strobe_drive.oe;
  endproperty
  a_preamble_drive: assert property (p_preamble_drive) else $error("preamble strobe late");

endmodule
`default_nettype wire

// ==== core/dram_training_map.svh ====
// constants for the training and mode register timing block
`ifndef DRAM_TRAINING_MAP_SVH
`define DRAM_TRAINING_MAP_SVH

// core clock period
`define CLK_PERIOD_NS 10

// command bus training answer delay, longest time, rounds down
`define ASYNC_TRAINING_READ_DELAY_NS 20
`define ASYNC_TRAINING_READ_DELAY_CYC (`ASYNC_TRAINING_READ_DELAY_NS / `CLK_PERIOD_NS)

// termination switch latency on training entry and exit
`define TERMINATION_ON_LATENCY_NS 20
`define TERMINATION_ON_LATENCY_CYC (`TERMINATION_ON_LATENCY_NS / `CLK_PERIOD_NS)
`define TERMINATION_OFF_LATENCY_NS 20
`define TERMINATION_OFF_LATENCY_CYC (`TERMINATION_OFF_LATENCY_NS / `CLK_PERIOD_NS)

// reference settle times, longest times
`define REFERENCE_MULTI_STEP_TIME_NS 250
`define REFERENCE_MULTI_STEP_TIME_CYC (`REFERENCE_MULTI_STEP_TIME_NS / `CLK_PERIOD_NS)
`define REFERENCE_SINGLE_STEP_TIME_NS 80
`define REFERENCE_SINGLE_STEP_TIME_CYC (`REFERENCE_SINGLE_STEP_TIME_NS / `CLK_PERIOD_NS)

// preamble training strobe drive delay, nanosecond part
`define PREAMBLE_TRAINING_DRIVE_DELAY_NS 20
`define PREAMBLE_TRAINING_DRIVE_DELAY_CYC (`PREAMBLE_TRAINING_DRIVE_DELAY_NS / `CLK_PERIOD_NS)

// data float on training exit, under one cycle so held at one
`define TRAINING_EXIT_OUTPUT_FLOAT_PS 1500
`define TRAINING_EXIT_OUTPUT_FLOAT_CYC \
  (((`TRAINING_EXIT_OUTPUT_FLOAT_PS / (`CLK_PERIOD_NS * 1000)) < 1) ? 1 : \
   (`TRAINING_EXIT_OUTPUT_FLOAT_PS / (`CLK_PERIOD_NS * 1000)))

// command/address field layout of a mode register write
`define CA_OP_MSB 5
`define CA_OP_LSB 4
`define CA_FIELD_MSB 3
`define CA_FIELD_LSB 2
`define CA_VALUE_MSB 1
`define CA_VALUE_LSB 0
`define MODE_WRITE_OP 2'h2

// mode field codes
`define FIELD_CBT_CODE 2'h0
`define FIELD_LEVEL_CODE 2'h1
`define FIELD_PREAMBLE_CODE 2'h2
`define FIELD_VREF_CODE 2'h3

// reset values
`define VREF_CODE_RESET 6'h00

`endif

// ==== core/dram_training_pkg.sv ====
// types shared by the training and mode register timing block
`include "dram_training_map.svh"
`default_nettype none
package dram_training_pkg;

  // command bus training answer states
  typedef enum logic [2:0] {
    CBT_IDLE = 3'b001,
    CBT_WAIT = 3'b010,
    CBT_SHOW = 3'b100
  } cbt_state_t;

  // mode fields reachable by a mode register write
  typedef enum logic [1:0] {
    FIELD_CBT      = `FIELD_CBT_CODE,
    FIELD_LEVEL    = `FIELD_LEVEL_CODE,
    FIELD_PREAMBLE = `FIELD_PREAMBLE_CODE,
    FIELD_VREF     = `FIELD_VREF_CODE
  } mode_field_t;

  // one decoded mode register write
  typedef struct packed {
    mode_field_t field;
    logic [1:0]  value;
  } mode_word_t;

  // drive of the strobe pair
  typedef struct packed {
    logic out_t;
    logic out_c;
    logic oe;
  } strobe_drive_t;

endpackage
`default_nettype wire

// ==== core/pin_sync.sv ====
// three-stage synchroniser that accepts a change once stages two and three agree
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1_reg;     // first stage, read only by s2
  logic [W-1:0] s2_reg;     // second stage
  logic [W-1:0] s3_reg;     // third stage
  logic [W-1:0] level_reg;  // accepted level
  logic [W-1:0] level_next;

  // take a bit only where stages two and three agree
  always_comb begin
    level_next = (~(s2_reg ^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & level_reg);
  end

  // chain and accepted level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      level_reg <= '0;
    end else begin
      s1_reg    <= pin;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule
`default_nettype wire

// ==== sim/ctrl_model.sv ====
// controller model: drives enable, select, command/address and strobe pins
`default_nettype none
module ctrl_model (
  input  wire logic       clk,
  input  wire logic       link_ck,
  output logic            cke_pin,
  output logic            cs_pin,
  output logic [5:0]      ca_pin,
  output logic            dqs_t_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle pins: awake, deselected, strobe low
  initial begin
    cke_pin = 1'b1;
    cs_pin = 1'b0;
    ca_pin = 6'h3f;
    dqs_t_in = 1'b0;
  end

  // one mode write, spaced from the one before
  task automatic mode_write(input logic [1:0] f, input logic [1:0] v);
    repeat (10) @(posedge link_ck);
    cs_pin <= 1'b1;
    ca_pin <= {2'h2, f, v};
    @(posedge link_ck);
    cs_pin <= 1'b0;
    ca_pin <= ~{2'h2, f, v};  // released bus shows the inverse
  endtask

  // move the enable pin with the clock valid before it
  task automatic set_cke(input logic v);
    repeat (2) @(posedge clk);  // strobe held low first
    repeat (3) @(posedge link_ck);
    cke_pin <= v;
  endtask

  // one training sample captured by a strobe rise
  task automatic sample(input logic [5:0] v);
    @(posedge link_ck);
    cs_pin <= 1'b1;
    ca_pin <= v;
    repeat (2) @(posedge link_ck);  // select before strobe
    cs_pin <= 1'b0;
    dqs_t_in <= 1'b1;
    repeat (2) @(posedge clk);
    dqs_t_in <= 1'b0;
    repeat (2) @(posedge clk);  // spacing to the next sample
  endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the training timing core
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MW = 7;  // mode write answer bound in cycles
  logic       clk = 1'b0;
  logic       link_ck = 1'b0;
  logic       rstn, cke_pin, cs_pin, dqs_t_in;
  logic [5:0] ca_pin, vref_code, exp_ca;
  logic [7:0] dq_out;
  logic       dq_oe, odt_on, vref_busy, cbt_mode, leveling_mode, preamble_mode;
  dram_training_pkg::strobe_drive_t strobe_drive;
  int         n_mismatch = 0;
  int         samples_checked = 0;

  // core clock and unrelated link clock, the link clock never stops
  always #5 clk = ~clk;
  always #62.5 link_ck = ~link_ck;

  dram_training_core #(.CA_W(6), .DQ_W(8), .TW(9)) dut_u (
    .clk(clk), .rstn(rstn), .link_ck(link_ck), .cke_pin(cke_pin), .cs_pin(cs_pin),
    .ca_pin(ca_pin), .dqs_t_in(dqs_t_in), .strobe_drive(strobe_drive), .dq_out(dq_out),
    .dq_oe(dq_oe), .odt_on(odt_on), .vref_busy(vref_busy), .vref_code(vref_code),
    .cbt_mode(cbt_mode), .leveling_mode(leveling_mode), .preamble_mode(preamble_mode));

  ctrl_model ctrl_u (.clk(clk), .link_ck(link_ck), .cke_pin(cke_pin), .cs_pin(cs_pin),
    .ca_pin(ca_pin), .dqs_t_in(dqs_t_in));

  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // output picked by index
  function automatic logic probe(input int k);
    case (k)
      0: return dq_oe;
      1: return odt_on;
      2: return strobe_drive.oe;
      3: return vref_busy;
      4: return cbt_mode;
      5: return leveling_mode;
      6: return dq_oe && (dq_out === {2'h0, exp_ca});
      default: return preamble_mode;
    endcase
  endfunction

  // bounded wait for a level, a run-out ends the run
  task automatic wait_level(input int k, input logic v, input int bound, input string name);
    for (int i = 0; i < bound && probe(k) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    check(name, 32'(probe(k)), 32'(v));
    if (probe(k) !== v) complete_run();
  endtask

  // outputs quiet while reset is held
  task automatic t_reset();
    check("strobe_drive", 32'(strobe_drive), 32'h2);
    check("quiet", {dq_oe, odt_on, vref_code, cbt_mode, preamble_mode}, 32'h0);
    $display("test reset done");
  endtask

  // single and multi step reference changes
  task automatic t_vref();
    ctrl_u.mode_write(dram_training_pkg::FIELD_VREF, 2'h1);
    wait_level(3, 1'b1, MW, "vref_busy");
    wait_level(3, 1'b0, 9, "vref_busy");
    check("vref_code", 32'(vref_code), 32'h1);
    ctrl_u.mode_write(dram_training_pkg::FIELD_VREF, 2'h2);
    wait_level(3, 1'b1, MW, "vref_busy");
    wait_level(3, 1'b0, 26, "vref_busy");
    check("vref_code", 32'(vref_code), 32'h3);
    $display("test vref done");
  endtask

  // leveling flag and preamble strobe drive on and off
  task automatic t_modes();
    ctrl_u.mode_write(dram_training_pkg::FIELD_LEVEL, 2'h1);
    wait_level(5, 1'b1, MW, "leveling_mode");
    ctrl_u.mode_write(dram_training_pkg::FIELD_PREAMBLE, 2'h1);
    wait_level(7, 1'b1, MW, "preamble_mode");
    wait_level(2, 1'b1, MW + 4, "strobe_oe");
    check("strobe_drive", 32'(strobe_drive), 32'h3);
    ctrl_u.mode_write(dram_training_pkg::FIELD_PREAMBLE, 2'h0);
    wait_level(2, 1'b0, MW + 1, "strobe_oe");
    wait_level(7, 1'b0, MW, "preamble_mode");
    ctrl_u.mode_write(dram_training_pkg::FIELD_LEVEL, 2'h0);
    wait_level(5, 1'b0, MW, "leveling_mode");
    $display("test modes done");
  endtask

  // training entry, two samples, exit
  task automatic t_cbt();
    logic [5:0] vals [2] = '{6'h2a, 6'h15};
    ctrl_u.mode_write(dram_training_pkg::FIELD_CBT, 2'h1);
    wait_level(4, 1'b1, MW, "cbt_mode");
    ctrl_u.set_cke(1'b0);
    wait_level(1, 1'b1, 8, "odt_on");
    repeat (3) @(posedge link_ck);  // first sample wait
    foreach (vals[i]) begin
      exp_ca = vals[i];
      ctrl_u.sample(vals[i]);
      wait_level(6, 1'b1, 8, "dq_sample");
    end
    ctrl_u.set_cke(1'b1);
    wait_level(0, 1'b0, 6, "dq_oe");
    wait_level(1, 1'b0, 8, "odt_on");
    ctrl_u.mode_write(dram_training_pkg::FIELD_CBT, 2'h0);
    wait_level(4, 1'b0, MW, "cbt_mode");
    $display("test training done");
  endtask

  // main sequence
  initial begin
    rstn = 1'b0;
    exp_ca = 6'h00;
    repeat (16) @(posedge clk);
    #1;
    t_reset();
    @(posedge clk);
    rstn <= 1'b1;
    t_vref();
    t_modes();
    t_cbt();
    complete_run();
  end
endmodule
`default_nettype wire
